// *** shared/rtccal_pkg.sv ***
`default_nettype none

package rtccal_pkg;

    // APB register map, byte addresses
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFF_HOUR = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_WEEKDAY = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_DATE = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_MONTH = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_YEAR = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h14;

    // Field widths, all fields start at bit 0
    localparam int HOUR_W = 6;
    localparam int WDAY_W = 3;
    localparam int DATE_W = 6;
    localparam int MON_W = 5;
    localparam int YEAR_W = 16;
    localparam int DIGIT_W = 4;
    localparam int YEAR_DIGITS = 4;

    // Control register bits
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_CARRY_BIT = 1;
    localparam logic CTRL_START_RESET = 1'b0;
    localparam logic CTRL_CARRY_RESET = 1'b0;

    // BCD digit values
    localparam logic [DIGIT_W-1:0] BCD_ZERO = 4'h0;
    localparam logic [DIGIT_W-1:0] BCD_NINE = 4'h9;
    localparam logic [DIGIT_W-1:0] BCD_ONE = 4'h1;

    // Counter limits in BCD
    localparam logic [HOUR_W-1:0] HOUR_FIRST = 6'h00;
    localparam logic [HOUR_W-1:0] HOUR_LAST = 6'h23;
    localparam logic [WDAY_W-1:0] WDAY_FIRST = 3'h0;
    localparam logic [WDAY_W-1:0] WDAY_LAST = 3'h6;
    localparam logic [DATE_W-1:0] DATE_FIRST = 6'h01;
    localparam logic [DATE_W-1:0] DATE_LAST_28 = 6'h28;
    localparam logic [DATE_W-1:0] DATE_LAST_29 = 6'h29;
    localparam logic [DATE_W-1:0] DATE_LAST_30 = 6'h30;
    localparam logic [DATE_W-1:0] DATE_LAST_31 = 6'h31;
    localparam logic [MON_W-1:0] MON_FIRST = 5'h01;
    localparam logic [MON_W-1:0] MON_FEB = 5'h02;
    localparam logic [MON_W-1:0] MON_APR = 5'h04;
    localparam logic [MON_W-1:0] MON_JUN = 5'h06;
    localparam logic [MON_W-1:0] MON_SEP = 5'h09;
    localparam logic [MON_W-1:0] MON_NOV = 5'h11;
    localparam logic [MON_W-1:0] MON_LAST = 5'h12;

endpackage

`default_nettype wire

// *** hw/rtccal_bcd_digit.sv ***
`default_nettype none

// One BCD digit of a ripple chain; wraps to zero after LAST
module rtccal_bcd_digit #(
    parameter logic [3:0] LAST = 4'h9
) (
    input wire logic [3:0] digit,
    input wire logic carry_in,
    output logic [3:0] digit_nxt,
    output logic carry_out
);
    import rtccal_pkg::*;

    wire at_last = (digit == LAST);

    assign carry_out = carry_in & at_last;
    assign digit_nxt = !carry_in ? digit :
                       at_last ? BCD_ZERO :
                       digit + BCD_ONE;

endmodule

`default_nettype wire

// *** hw/rtccal_top.sv ***
// The APB slave port and the register addresses were left to the implementer.
`default_nettype none

// Functional notes
// [R1] Weekday advances by one on every daily carry.
// [R2] Weekday code 0 is Sunday through 6 for Saturday, three bits.
// [R3] Weekday sits in bits 2..0; bits 7..3 read zero.
// [R4] Date advances by one on every daily carry from the hour counter.
// [R5] Date stays 01..31, last day set by month and leap year.
// [R6] Date BCD: tens in bits 5..4, units 3..0, bits 7..6 read zero.
// [R7] Month advances by one on every monthly carry from the date.
// [R8] Month stays within 01..12.
// [R9] Month BCD: tens in bit 4, units 3..0, bits 7..5 read zero.
// [R10] Four-digit year in 16 bits, advanced by each yearly carry.
// [R11] Year values 0000 through 9999 are supported.
// [R12] Year digits: thousands 15..12, hundreds 11..8, tens 7..4, units 3..0.
// [R13] Leap year when year is a multiple of four, including 0000.
// [R14] Software stops counting with the start bit before writing calendar counters.
// [R15] Software writes year only when halted, or checks the carry flag.
// [R16] Counters keep their contents across every reset and standby.
// [R17] Software writes zero to reserved bits.
// [R18] Software loads only in-range BCD values.
// [R19] Hour counter stays 00..23; daily carry when it passes 23.
// [R20] Weekday wraps 6 to 0; date wraps to 01 with a monthly carry.
// [R21] Month wraps 12 to 01 with a yearly carry; year wraps 9999 to 0000.
module rtccal_top (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rtccal_pkg::ADDR_W-1:0] paddr,
    input wire logic [rtccal_pkg::DATA_W-1:0] pwdata,
    output logic [rtccal_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hour_tick,
    output logic count_running,
    output logic [rtccal_pkg::HOUR_W-1:0] hour_value,
    output logic [rtccal_pkg::WDAY_W-1:0] weekday_value,
    output logic [rtccal_pkg::DATE_W-1:0] date_value,
    output logic [rtccal_pkg::MON_W-1:0] month_value,
    output logic [rtccal_pkg::YEAR_W-1:0] year_value
);
    import rtccal_pkg::*;

    // Two-digit BCD increment; callers wrap before the tens digit overflows
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (v[3:0] == BCD_NINE) begin
            r[3:0] = BCD_ZERO;
            r[7:4] = v[7:4] + BCD_ONE;
        end else begin
            r[3:0] = v[3:0] + BCD_ONE;
        end
        return r;
    endfunction

    // ---------------- Register state ----------------
    // Calendar counters carry no reset at all: they must survive every reset
    logic [HOUR_W-1:0] hour_count_r;
    logic [WDAY_W-1:0] weekday_count_r;
    logic [DATE_W-1:0] date_count_r;
    logic [MON_W-1:0] month_count_r;
    logic [YEAR_W-1:0] year_count_r;
    logic start_r;
    logic carry_flag_r;
    logic [DATA_W-1:0] prdata_r;

    // ---------------- APB decode ----------------
    wire setup_phase = psel & ~penable;
    wire access_phase = psel & penable;
    wire wr_access = access_phase & pwrite;

    wire sel_hour = (paddr == OFF_HOUR);
    wire sel_weekday = (paddr == OFF_WEEKDAY);
    wire sel_date = (paddr == OFF_DATE);
    wire sel_month = (paddr == OFF_MONTH);
    wire sel_year = (paddr == OFF_YEAR);
    wire sel_ctrl = (paddr == OFF_CTRL);
    wire sel_mapped = sel_hour | sel_weekday | sel_date | sel_month | sel_year | sel_ctrl;

    wire wr_hour = wr_access & sel_hour;
    wire wr_weekday = wr_access & sel_weekday;
    wire wr_date = wr_access & sel_date;
    wire wr_month = wr_access & sel_month;
    wire wr_year = wr_access & sel_year;
    wire wr_ctrl = wr_access & sel_ctrl;

    // Zero wait states; unmapped addresses answer with an error and no effect
    assign pready = 1'b1;
    assign pslverr = access_phase & ~sel_mapped;

    // Reserved bits above each field are dropped on write and read back as zero
    wire [HOUR_W-1:0] wdata_hour = pwdata[HOUR_W-1:0];
    wire [WDAY_W-1:0] wdata_weekday = pwdata[WDAY_W-1:0]; // [R3]
    wire [DATE_W-1:0] wdata_date = pwdata[DATE_W-1:0]; // [R6]
    wire [MON_W-1:0] wdata_month = pwdata[MON_W-1:0]; // [R9]
    wire [YEAR_W-1:0] wdata_year = pwdata[YEAR_W-1:0]; // [R12]

    wire [DATA_W-1:0] rd_hour = {{(DATA_W-HOUR_W){1'b0}}, hour_count_r};
    wire [DATA_W-1:0] rd_weekday = {{(DATA_W-WDAY_W){1'b0}}, weekday_count_r}; // [R3]
    wire [DATA_W-1:0] rd_date = {{(DATA_W-DATE_W){1'b0}}, date_count_r}; // [R6]
    wire [DATA_W-1:0] rd_month = {{(DATA_W-MON_W){1'b0}}, month_count_r}; // [R9]
    wire [DATA_W-1:0] rd_year = {{(DATA_W-YEAR_W){1'b0}}, year_count_r}; // [R12]
    wire [DATA_W-1:0] rd_ctrl = {{(DATA_W-2){1'b0}}, carry_flag_r, start_r};

    wire [DATA_W-1:0] rd_mux =
        sel_hour ? rd_hour :
        sel_weekday ? rd_weekday :
        sel_date ? rd_date :
        sel_month ? rd_month :
        sel_year ? rd_year :
        sel_ctrl ? rd_ctrl :
        {DATA_W{1'b0}};

    // Read data is captured in the setup cycle so prdata comes from a flop
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_r <= {DATA_W{1'b0}};
        end else if (setup_phase && !pwrite) begin
            prdata_r <= rd_mux;
        end
    end

    assign prdata = prdata_r;

    // ---------------- Count chain ----------------
    // Hour ticks are lost while stopped, which is what makes halted writes safe
    wire tick = start_r & hour_tick;

    wire hour_at_last = (hour_count_r == HOUR_LAST);
    wire day_carry = tick & hour_at_last; // [R19]

    // Leap test on the BCD year: multiple of four, 0000 included
    wire [DIGIT_W-1:0] year_units = year_count_r[DIGIT_W-1:0];
    wire year_tens_odd = year_count_r[DIGIT_W];
    wire units_mod4_zero = (year_units == 4'h0) | (year_units == 4'h4) | (year_units == 4'h8);
    wire units_mod4_two = (year_units == 4'h2) | (year_units == 4'h6);
    wire leap_year = year_tens_odd ? units_mod4_two : units_mod4_zero; // [R13]

    wire short_month = (month_count_r == MON_APR) | (month_count_r == MON_JUN) |
                       (month_count_r == MON_SEP) | (month_count_r == MON_NOV);
    wire feb_month = (month_count_r == MON_FEB);

    wire [DATE_W-1:0] date_last =
        feb_month ? (leap_year ? DATE_LAST_29 : DATE_LAST_28) :
        short_month ? DATE_LAST_30 :
        DATE_LAST_31; // [R5]

    wire date_at_last = (date_count_r == date_last);
    wire month_carry = day_carry & date_at_last; // [R20]
    wire month_at_last = (month_count_r == MON_LAST);
    wire year_carry = month_carry & month_at_last; // [R21]

    // Next values
    wire [7:0] hour_inc8 = bcd_inc({{(8-HOUR_W){1'b0}}, hour_count_r});
    wire [7:0] date_inc8 = bcd_inc({{(8-DATE_W){1'b0}}, date_count_r});
    wire [7:0] month_inc8 = bcd_inc({{(8-MON_W){1'b0}}, month_count_r});

    wire [HOUR_W-1:0] hour_nxt = hour_at_last ? HOUR_FIRST : hour_inc8[HOUR_W-1:0]; // [R19]

    // Codes 0..6 are plain binary, which equals BCD in this range
    wire [WDAY_W-1:0] weekday_nxt = (weekday_count_r == WDAY_LAST) ? WDAY_FIRST :
                                    weekday_count_r + 3'h1; // [R2] [R20]

    wire [DATE_W-1:0] date_nxt = date_at_last ? DATE_FIRST : date_inc8[DATE_W-1:0]; // [R20]

    wire [MON_W-1:0] month_nxt = month_at_last ? MON_FIRST : month_inc8[MON_W-1:0]; // [R8] [R21]

    // Year: four BCD digit stages in a ripple chain, 9999 rolls to 0000
    logic [YEAR_DIGITS:0] year_chain;
    logic [YEAR_W-1:0] year_nxt;

    assign year_chain[0] = year_carry; // [R10]

    genvar gi;
    generate
        for (gi = 0; gi < YEAR_DIGITS; gi++) begin : g_year_digit
            rtccal_bcd_digit #(
                .LAST(BCD_NINE)
            ) u_digit (
                .digit(year_count_r[gi*DIGIT_W +: DIGIT_W]),
                .carry_in(year_chain[gi]),
                .digit_nxt(year_nxt[gi*DIGIT_W +: DIGIT_W]),
                .carry_out(year_chain[gi+1])
            ); // [R11] [R21]
        end
    endgenerate

    // ---------------- Counters, no reset ----------------
    // A bus write wins over a tick in the same cycle; software is expected to halt first
    always_ff @(posedge core_clk) begin
        if (wr_hour) begin
            hour_count_r <= wdata_hour;
        end else if (tick) begin
            hour_count_r <= hour_nxt; // [R19]
        end
    end

    always_ff @(posedge core_clk) begin
        if (wr_weekday) begin
            weekday_count_r <= wdata_weekday; // [R14]
        end else if (day_carry) begin
            weekday_count_r <= weekday_nxt; // [R1] [R16]
        end
    end

    always_ff @(posedge core_clk) begin
        if (wr_date) begin
            date_count_r <= wdata_date; // [R14]
        end else if (day_carry) begin
            date_count_r <= date_nxt; // [R4] [R16]
        end
    end

    always_ff @(posedge core_clk) begin
        if (wr_month) begin
            month_count_r <= wdata_month; // [R14]
        end else if (month_carry) begin
            month_count_r <= month_nxt; // [R7] [R16]
        end
    end

    always_ff @(posedge core_clk) begin
        if (wr_year) begin
            year_count_r <= wdata_year; // [R15]
        end else if (year_carry) begin
            year_count_r <= year_nxt; // [R10] [R16]
        end
    end

    // ---------------- Control ----------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            start_r <= CTRL_START_RESET;
        end else if (wr_ctrl) begin
            start_r <= pwdata[CTRL_START_BIT]; // [R14]
        end
    end

    // Carry flag: set by every counted tick, cleared by writing zero; set wins
    wire carry_clear = wr_ctrl & ~pwdata[CTRL_CARRY_BIT];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            carry_flag_r <= CTRL_CARRY_RESET;
        end else if (tick) begin
            carry_flag_r <= 1'b1; // [R15]
        end else if (carry_clear) begin
            carry_flag_r <= 1'b0;
        end
    end

    // ---------------- Outputs to the rest of the unit ----------------
    assign count_running = start_r;
    assign hour_value = hour_count_r;
    assign weekday_value = weekday_count_r;
    assign date_value = date_count_r;
    assign month_value = month_count_r;
    assign year_value = year_count_r;

endmodule

`default_nettype wire

// *** test/rtccal_top_chk.sv ***
`default_nettype none

module rtccal_top_chk (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rtccal_pkg::ADDR_W-1:0] paddr,
    input wire logic [rtccal_pkg::DATA_W-1:0] pwdata,
    input wire logic [rtccal_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hour_tick,
    input wire logic count_running,
    input wire logic [rtccal_pkg::HOUR_W-1:0] hour_value,
    input wire logic [rtccal_pkg::WDAY_W-1:0] weekday_value,
    input wire logic [rtccal_pkg::DATE_W-1:0] date_value,
    input wire logic [rtccal_pkg::MON_W-1:0] month_value,
    input wire logic [rtccal_pkg::YEAR_W-1:0] year_value
);
    import rtccal_pkg::*;
    // Bus writes override a tick, so every day check excludes them
    wire logic wr = psel && penable && pwrite;
    wire logic day = hour_tick && count_running && !wr && hour_value == HOUR_LAST;
    wire logic [3:0] yu = year_value[3:0];
    // Last two digits as binary; hundreds never change a multiple of four
    wire logic [7:0] y2 = year_value[7:4] * 8'd10 + {4'h0, yu};
    wire logic leap = (y2[1:0] == 2'b00);
    wire logic yend = day && month_value == MON_LAST && date_value == DATE_LAST_31;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    AST_HOUR_WRAP: assert property (day |=> hour_value == HOUR_FIRST)
        else $error("hour did not wrap to 00");
    AST_WDAY_INC: assert property (day && weekday_value != WDAY_LAST
        |=> weekday_value == $past(weekday_value) + 3'h1)
        else $error("weekday did not advance");
    AST_WDAY_WRAP: assert property (day && weekday_value == WDAY_LAST |=> weekday_value == WDAY_FIRST)
        else $error("weekday did not wrap");
    AST_FEB_LEAP: assert property (day && leap && month_value == MON_FEB && date_value == DATE_LAST_28
        |=> date_value == DATE_LAST_29 && month_value == MON_FEB)
        else $error("leap february ended early");
    AST_FEB_END: assert property (day && !leap && month_value == MON_FEB && date_value == DATE_LAST_28
        |=> date_value == DATE_FIRST && month_value == 5'h03)
        else $error("plain february did not end at 28");
    AST_MON_WRAP: assert property (yend |=> month_value == MON_FIRST && date_value == DATE_FIRST)
        else $error("december did not wrap");
    AST_YEAR_WRAP: assert property (yend && year_value == 16'h9999 |=> year_value == 16'h0000)
        else $error("year did not wrap to 0000");
    AST_HALT: assert property (hour_tick && !count_running && !wr
        |=> $stable(hour_value) && $stable(date_value) && $stable(weekday_value))
        else $error("counted while halted");
    AST_RANGE: assert property (count_running |-> month_value >= MON_FIRST && month_value <= MON_LAST)
        else $error("month out of range");
    AST_SLVERR: assert property (psel && penable && paddr > OFF_CTRL |-> pslverr)
        else $error("unmapped access without error");
    AST_READY: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    cover property (yend && year_value == 16'h9999);
    cover property (day && leap && month_value == MON_FEB);
    cover property (psel && penable && pslverr);
endmodule

bind rtccal_top rtccal_top_chk u_chk (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .hour_tick, .count_running, .hour_value, .weekday_value, .date_value, .month_value,
    .year_value);

`default_nettype wire

// *** test/rtccal_top_test.sv ***
`default_nettype none

module rtccal_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    import rtccal_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic hour_tick = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata, rd;
    logic pready, pslverr, count_running, err;
    logic [HOUR_W-1:0] hour_value;
    logic [WDAY_W-1:0] weekday_value;
    logic [DATE_W-1:0] date_value;
    logic [MON_W-1:0] month_value;
    logic [YEAR_W-1:0] year_value;
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;
    // Start state then expected state: hour, weekday, date, month, year
    logic [95:0] cases [11] = '{
        96'h23_06_28_02_2023_00_00_01_03_2023, 96'h23_02_28_02_2024_00_03_29_02_2024,
        96'h23_02_29_02_2024_00_03_01_03_2024, 96'h23_04_28_02_0000_00_05_29_02_0000,
        96'h23_05_30_04_2100_00_06_01_05_2100, 96'h23_01_30_01_1999_00_02_31_01_1999,
        96'h23_00_30_09_2009_00_01_01_10_2009, 96'h23_03_31_12_2019_00_04_01_01_2020,
        96'h23_06_31_12_9999_00_00_01_01_0000, 96'h09_01_15_06_2022_10_01_15_06_2022,
        96'h23_01_28_02_2100_00_02_29_02_2100};

    always #25 core_clk = ~core_clk;

    rtccal_top dut (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .hour_tick, .count_running, .hour_value, .weekday_value, .date_value, .month_value, .year_value);

    task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [DATA_W-1:0] fld(input logic [47:0] v, input int i);
        return (i == 4) ? {16'h0, v[15:0]} : {24'h0, v[47-8*i -: 8]};
    endfunction

    // Halts first, since loading a running calendar is not allowed
    task automatic load(input logic [47:0] v);
        apb(1'b1, OFF_CTRL, 32'h0);
        for (int i = 0; i < 5; i++) apb(1'b1, 8'(4 * i), fld(v, i));
    endtask

    task automatic verify(input logic [47:0] v);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check($sformatf("reg %0h", 4 * i), rd, fld(v, i));
        end
    endtask

    task automatic tick;
        @(posedge core_clk);
        hour_tick <= 1'b1;
        @(posedge core_clk);
        hour_tick <= 1'b0;
    endtask

    initial begin
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        apb(1'b0, OFF_CTRL, 32'h0);
        check("ctrl after reset", rd, 32'h0);
        foreach (cases[k]) begin
            load(cases[k][95:48]);
            apb(1'b1, OFF_CTRL, 32'h1);
            tick();
            check("running", {31'h0, count_running}, 32'h1);
            apb(1'b0, OFF_CTRL, 32'h0);
            check("ctrl", rd, 32'h3);
            verify(cases[k][47:0]);
        end
        load(48'h23_03_31_12_2019);
        tick();
        verify(48'h23_03_31_12_2019);
        apb(1'b0, OFF_CTRL, 32'h0);
        check("ctrl while halted", rd, 32'h0);
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        verify(48'h23_03_31_12_2019);
        check("running after reset", {31'h0, count_running}, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped data", rd, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        conclude();
    end

    // A hang would otherwise never reach the verdict
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 5000) begin
            error_cnt++;
            conclude();
        end
    end
endmodule

`default_nettype wire
